/* File: port_six_seven_pin_config.sv */
`timescale 1ns/100ps
`default_nettype none
module port_six_seven_pin_config (
	// clock and reset
	input  wire logic                                clock,
	input  wire logic                                nrst,
	// avalon-mm slave
	input  wire logic [pin_config_pkg::ADDR_W-1:0]   avs_address,
	input  wire logic                                avs_read,
	input  wire logic                                avs_write,
	input  wire logic [pin_config_pkg::DATA_W-1:0]   avs_writedata,
	input  wire logic [3:0]                          avs_byteenable,
	output logic      [pin_config_pkg::DATA_W-1:0]   avs_readdata,
	output logic                                     avs_waitrequest,
	// port 6 pin state from its other control registers
	input  wire logic [7:0]                          port6_out_data,
	input  wire logic [7:0]                          port6_out_en,
	input  wire logic [7:0]                          port6_alt_en,
	input  wire logic [7:0]                          port6_pullup_en,
	// port 6 pads
	output logic      [7:0]                          port6_pad_out,
	output logic      [7:0]                          port6_pad_oe,
	output logic      [7:0]                          port6_pullup_on,
	// lcd segment sources for port 7
	input  wire logic                                lcd_segment_36,
	input  wire logic                                lcd_segment_37,
	input  wire logic                                lcd_segment_38,
	input  wire logic                                lcd_segment_39,
	input  wire logic                                lcd_segment_40,
	input  wire logic                                lcd_segment_41,
	input  wire logic                                lcd_segment_42,
	input  wire logic                                lcd_segment_43,
	// port 7 pads
	input  wire logic [7:0]                          port7_pad_in,
	output logic      [7:0]                          port7_pad_out,
	output logic      [7:0]                          port7_pad_oe
);
	logic [7:0]                            port7_upper_config_reg_r;
	logic [7:0]                            port7_upper_config_reg_nxt;
	logic [7:0]                            port7_lower_config_reg_r;
	logic [7:0]                            port7_lower_config_reg_nxt;
	logic [7:0]                            port6_drive_type_reg_r;
	logic [7:0]                            port6_drive_type_reg_nxt;
	logic [7:0]                            port7_data_r;
	logic [7:0]                            port7_data_nxt;
	logic [pin_config_pkg::DATA_W-1:0]     readdata_r;
	logic [pin_config_pkg::DATA_W-1:0]     readdata_nxt;
	pin_config_pkg::rd_state_t             rd_state_r;
	pin_config_pkg::rd_state_t             rd_state_nxt;
	logic [pin_config_pkg::IDX_W-1:0]      word_idx;
	logic                                  wr_lane0;
	logic [15:0]                           p7_config;
	logic [7:0]                            p7_drive_port;
	logic [7:0]                            p7_drive_lcd;
	logic [7:0]                            lcd_segments;
	logic [7:0]                            p6_out_r;
	logic [7:0]                            p6_out_nxt;
	logic [7:0]                            p6_oe_r;
	logic [7:0]                            p6_oe_nxt;
	logic [7:0]                            p6_pull_r;
	logic [7:0]                            p6_pull_nxt;
	logic [7:0]                            p7_out_r;
	logic [7:0]                            p7_out_nxt;
	logic [7:0]                            p7_oe_r;
	logic [7:0]                            p7_oe_nxt;

	// bus decode
	assign word_idx = avs_address[pin_config_pkg::ADDR_W-1:2];
	assign wr_lane0 = avs_write & avs_byteenable[0];
	assign avs_waitrequest = avs_read & (rd_state_r == pin_config_pkg::RD_IDLE);
	assign avs_readdata    = readdata_r;

	always_comb begin
		port7_upper_config_reg_nxt = port7_upper_config_reg_r;
		port7_lower_config_reg_nxt = port7_lower_config_reg_r;
		port6_drive_type_reg_nxt   = port6_drive_type_reg_r;
		port7_data_nxt             = port7_data_r;
		if (wr_lane0) begin
			unique case (word_idx)
				pin_config_pkg::IDX_P7_UPPER: port7_upper_config_reg_nxt = avs_writedata[7:0]; // RQ3
				pin_config_pkg::IDX_P7_LOWER: port7_lower_config_reg_nxt = avs_writedata[7:0]; // RQ4
				pin_config_pkg::IDX_P6_DRIVE: port6_drive_type_reg_nxt   = avs_writedata[7:0]; // RQ2
				pin_config_pkg::IDX_P7_DATA:  port7_data_nxt             = avs_writedata[7:0];
				default:                      port7_data_nxt             = port7_data_r;
			endcase
		end
	end

	// read answer one cycle after the request
	always_comb begin
		rd_state_nxt = pin_config_pkg::RD_IDLE;
		readdata_nxt = readdata_r;
		unique case (rd_state_r)
			pin_config_pkg::RD_IDLE: begin
				if (avs_read) begin
					rd_state_nxt = pin_config_pkg::RD_ANSWER;
					readdata_nxt = '0;
					unique case (word_idx)
						pin_config_pkg::IDX_P7_UPPER: readdata_nxt[7:0] = port7_upper_config_reg_r;
						pin_config_pkg::IDX_P7_LOWER: readdata_nxt[7:0] = port7_lower_config_reg_r;
						pin_config_pkg::IDX_P6_DRIVE: readdata_nxt[7:0] = port6_drive_type_reg_r;
						pin_config_pkg::IDX_P7_DATA:  readdata_nxt[7:0] = port7_data_r;
						pin_config_pkg::IDX_P7_PINS:  readdata_nxt[7:0] = port7_pad_in;
						default:                      readdata_nxt      = '0;
					endcase
				end
			end
			pin_config_pkg::RD_ANSWER: rd_state_nxt = pin_config_pkg::RD_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			port7_upper_config_reg_r <= pin_config_pkg::RST_P7_UPPER;
			port7_lower_config_reg_r <= pin_config_pkg::RST_P7_LOWER;
			port6_drive_type_reg_r   <= pin_config_pkg::RST_P6_DRIVE;
			port7_data_r             <= pin_config_pkg::RST_P7_DATA;
			readdata_r               <= '0;
			rd_state_r               <= pin_config_pkg::RD_IDLE;
		end else begin
			port7_upper_config_reg_r <= port7_upper_config_reg_nxt;
			port7_lower_config_reg_r <= port7_lower_config_reg_nxt;
			port6_drive_type_reg_r   <= port6_drive_type_reg_nxt;
			port7_data_r             <= port7_data_nxt;
			readdata_r               <= readdata_nxt;
			rd_state_r               <= rd_state_nxt;
		end
	end

	// port 7 field decode, pin i uses config bits 2i+1..2i
	assign p7_config    = {port7_upper_config_reg_r, port7_lower_config_reg_r}; // RQ3 RQ4
	assign lcd_segments = {lcd_segment_43, lcd_segment_42, lcd_segment_41, lcd_segment_40,
	                       lcd_segment_39, lcd_segment_38, lcd_segment_37, lcd_segment_36};

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_p7_pin
			pin_mode_decode u_decode (
				.code       (p7_config[2*gi+1:2*gi]),
				.drive_port (p7_drive_port[gi]),
				.drive_lcd  (p7_drive_lcd[gi])
			);
		end
	endgenerate

	// pad drive
	always_comb begin
		p7_oe_nxt  = p7_drive_port | p7_drive_lcd; // RQ5
		p7_out_nxt = (p7_drive_port & port7_data_r) | (p7_drive_lcd & lcd_segments); // RQ5
		p6_out_nxt = port6_out_data;
		p6_oe_nxt  = port6_out_en & (~port6_drive_type_reg_r | ~port6_out_data); // RQ2 RQ8
		p6_pull_nxt = port6_pullup_en
			& ~((port6_out_en & ~port6_drive_type_reg_r) | port6_alt_en); // RQ1
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			p7_out_r  <= '0;
			p7_oe_r   <= '0;
			p6_out_r  <= '0;
			p6_oe_r   <= '0;
			p6_pull_r <= '0;
		end else begin
			p7_out_r  <= p7_out_nxt;
			p7_oe_r   <= p7_oe_nxt;
			p6_out_r  <= p6_out_nxt;
			p6_oe_r   <= p6_oe_nxt;
			p6_pull_r <= p6_pull_nxt;
		end
	end

	assign port7_pad_out   = p7_out_r;
	assign port7_pad_oe    = p7_oe_r;
	assign port6_pad_out   = p6_out_r;
	assign port6_pad_oe    = p6_oe_r;
	assign port6_pullup_on = p6_pull_r;

	// checks
	property p_p6_pullup;
		@(posedge clock) disable iff (!nrst)
		1'b1 |=> port6_pullup_on == ($past(port6_pullup_en) & ~(($past(port6_out_en)
			& ~$past(port6_drive_type_reg_r)) | $past(port6_alt_en)));
	endproperty
	a_p6_pullup: assert property (p_p6_pullup) else $error("port 6 pull-up wrong"); // RQ1

	property p_p6_drive_write;
		@(posedge clock) disable iff (!nrst)
		(wr_lane0 && word_idx == pin_config_pkg::IDX_P6_DRIVE)
			|=> port6_drive_type_reg_r == $past(avs_writedata[7:0]);
	endproperty
	a_p6_drive_write: assert property (p_p6_drive_write) else $error("drive type not stored"); // RQ2

	property p_p6_open_drain;
		@(posedge clock) disable iff (!nrst)
		(port6_out_en[0] && port6_drive_type_reg_r[0] && port6_out_data[0]) |=> !port6_pad_oe[0];
	endproperty
	a_p6_open_drain: assert property (p_p6_open_drain) else $error("open-drain drove high"); // RQ2

	property p_p6_input;
		@(posedge clock) disable iff (!nrst)
		!port6_out_en[3] |=> !port6_pad_oe[3];
	endproperty
	a_p6_input: assert property (p_p6_input) else $error("input pin driven"); // RQ8

	property p_p7_upper_out;
		@(posedge clock) disable iff (!nrst)
		(port7_upper_config_reg_r[7:6] == pin_config_pkg::CODE_OUTPUT)
			|=> port7_pad_oe[7] && port7_pad_out[7] == $past(port7_data_r[7]);
	endproperty
	a_p7_upper_out: assert property (p_p7_upper_out) else $error("pin 7 not output"); // RQ3

	property p_p7_lower_lcd;
		@(posedge clock) disable iff (!nrst)
		(port7_lower_config_reg_r[1:0] == pin_config_pkg::CODE_LCD)
			|=> port7_pad_oe[0] && port7_pad_out[0] == $past(lcd_segment_36);
	endproperty
	a_p7_lower_lcd: assert property (p_p7_lower_lcd) else $error("pin 0 not lcd"); // RQ4

	property p_p7_input;
		@(posedge clock) disable iff (!nrst)
		(port7_upper_config_reg_r[1:0] == pin_config_pkg::CODE_INPUT) ##1
			(port7_upper_config_reg_r[1:0] == pin_config_pkg::CODE_INPUT) |=> !port7_pad_oe[4];
	endproperty
	a_p7_input: assert property (p_p7_input) else $error("pin 4 input driven"); // RQ5

	property p_read_answer;
		@(posedge clock) disable iff (!nrst)
		(avs_read && avs_waitrequest) |=> (avs_read -> !avs_waitrequest);
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer late");
endmodule // port_six_seven_pin_config
`default_nettype wire

/* File: pin_config_pkg.sv */
// What this block does
// RQ1 - port 6 pull-up drops only for push-pull output or alternative function
// RQ2 - port 6 drive type register: bit per pin, 0 push-pull, 1 open-drain
// RQ3 - port 7 pins 7..4 set by upper config register, two bits each
// RQ4 - port 7 pins 3..0 set by lower config register, two bits each
// RQ5 - port 7 field: 00 input, 11 driven output, 10 lcd segment output
// RQ6 - software never writes code 01 into a port 7 field
// RQ7 - software reaches the port 7 config registers by register addressing only
// RQ8 - push-pull or open-drain choice acts only while the port 6 pin drives
package pin_config_pkg;
	localparam int                 ADDR_W            = 10;
	localparam int                 DATA_W            = 32;
	localparam int                 REG_W             = 8;
	localparam int                 IDX_W             = 8;
	// word indices; byte address is four times the index
	localparam logic [IDX_W-1:0]   IDX_P7_UPPER      = 8'h1C;
	localparam logic [IDX_W-1:0]   IDX_P7_LOWER      = 8'h1D;
	localparam logic [IDX_W-1:0]   IDX_P6_DRIVE      = 8'hF5;
	localparam logic [IDX_W-1:0]   IDX_P7_DATA       = 8'h20;
	localparam logic [IDX_W-1:0]   IDX_P7_PINS       = 8'h21;
	localparam logic [REG_W-1:0]   RST_P7_UPPER      = 8'h00;
	localparam logic [REG_W-1:0]   RST_P7_LOWER      = 8'h00;
	localparam logic [REG_W-1:0]   RST_P6_DRIVE      = 8'h00;
	localparam logic [REG_W-1:0]   RST_P7_DATA       = 8'h00;
	localparam logic [1:0]         CODE_INPUT        = 2'h0;
	localparam logic [1:0]         CODE_RESERVED     = 2'h1;
	localparam logic [1:0]         CODE_LCD          = 2'h2;
	localparam logic [1:0]         CODE_OUTPUT       = 2'h3;
	localparam logic               DRIVE_PUSH_PULL   = 1'h0;
	localparam logic               DRIVE_OPEN_DRAIN  = 1'h1;

	typedef enum logic [0:0] {
		RD_IDLE   = 1'h0,
		RD_ANSWER = 1'h1
	} rd_state_t;
endpackage

/* File: pin_mode_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_mode_decode (
	// field
	input  wire logic [1:0] code,
	// decoded mode
	output logic            drive_port,
	output logic            drive_lcd
);
	always_comb begin
		drive_port = 1'b0;
		drive_lcd  = 1'b0;
		unique case (code)
			pin_config_pkg::CODE_OUTPUT:   drive_port = 1'b1; // RQ5
			pin_config_pkg::CODE_LCD:      drive_lcd  = 1'b1; // RQ5
			pin_config_pkg::CODE_INPUT:    drive_port = 1'b0; // RQ5
			pin_config_pkg::CODE_RESERVED: drive_port = 1'b0;
		endcase
	end
endmodule // pin_mode_decode
`default_nettype wire

/* File: pad_world.sv */
`timescale 1ns/100ps
`default_nettype none
module pad_world (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       nrst,
	// port 7 pads as driven by the block
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe,
	// lcd segment sources and pin levels
	output logic      [7:0] seg,
	output logic      [7:0] pad_in
);
	logic [7:0] seg_r;
	logic [7:0] seg_nxt;
	logic [7:0] last_r;
	logic [7:0] last_nxt;
	// segment pattern moves every cycle; undriven pins flip every cycle
	always_comb begin
		seg_nxt  = {seg_r[6:0], ~seg_r[7]};
		last_nxt = pad_in;
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			seg_r  <= 8'h00;
			last_r <= 8'h00;
		end else begin
			seg_r  <= seg_nxt;
			last_r <= last_nxt;
		end
	end
	assign seg    = seg_r;
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ~last_r);
endmodule // pad_world
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	typedef struct packed {
		logic [7:0] p7u, p7l, p7d, dt, d6, e6, a6, u6, x_oe7, x_oe6, x_pu6;
	} row_t;
	row_t rows [5] = '{
		'{8'hFF, 8'hFF, 8'h5A, 8'h00, 8'h0F, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00},
		'{8'hAA, 8'hAA, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hF0, 8'hFF},
		'{8'h00, 8'h00, 8'hFF, 8'h0F, 8'h33, 8'h3C, 8'hC0, 8'hF5, 8'h00, 8'h3C, 8'h05},
		'{8'hE0, 8'h0B, 8'hC3, 8'h55, 8'hAA, 8'hF0, 8'h0F, 8'hFF, 8'hC3, 8'hF0, 8'h50},
		'{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF}};
	logic        clock = 1'h0;
	logic        nrst = 1'h0;
	logic [9:0]  avs_address = 10'h000;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [7:0]  d6 = 8'h00, e6 = 8'h00, a6 = 8'h00, u6 = 8'h00, seg_q = 8'h00;
	logic [31:0] q;
	wire logic [31:0] avs_readdata;
	wire logic        avs_waitrequest;
	wire logic [7:0]  pad6_out, pad6_oe, pu6, pad7_out, pad7_oe, pad7_in, seg;
	int          mismatches = 0;
	int          check_count = 0;
	always #25 clock = ~clock;
	always @(posedge clock) seg_q <= seg;
	port_six_seven_pin_config u_port_six_seven_pin_config (.clock(clock), .nrst(nrst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.port6_out_data(d6), .port6_out_en(e6), .port6_alt_en(a6), .port6_pullup_en(u6),
		.port6_pad_out(pad6_out), .port6_pad_oe(pad6_oe), .port6_pullup_on(pu6),
		.lcd_segment_36(seg[0]), .lcd_segment_37(seg[1]), .lcd_segment_38(seg[2]),
		.lcd_segment_39(seg[3]), .lcd_segment_40(seg[4]), .lcd_segment_41(seg[5]),
		.lcd_segment_42(seg[6]), .lcd_segment_43(seg[7]),
		.port7_pad_in(pad7_in), .port7_pad_out(pad7_out), .port7_pad_oe(pad7_oe));
	pad_world u_pad_world (.clock(clock), .nrst(nrst), .pad_out(pad7_out),
		.pad_oe(pad7_oe), .seg(seg), .pad_in(pad7_in));
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wait_ack;
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'h0);
	endtask
	// software reaches registers by plain register access only
	task automatic bus_wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
		@(posedge clock);
		avs_address <= {idx, 2'h0};
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		avs_write <= 1'h1;
		wait_ack();
		avs_write <= 1'h0;
	endtask
	task automatic bus_rd(input logic [7:0] idx, output logic [31:0] d);
		@(posedge clock);
		avs_address <= {idx, 2'h0};
		avs_read <= 1'h1;
		wait_ack();
		d = avs_readdata;
		avs_read <= 1'h0;
	endtask
	function automatic logic [7:0] exp7(input row_t r, input logic [7:0] s);
		logic [15:0] f;
		logic [7:0]  e;
		f = {r.p7u, r.p7l};
		for (int i = 0; i < 8; i++) begin
			case (f[2*i+:2])
				2'h3: e[i] = r.p7d[i];
				2'h2: e[i] = s[i];
				default: e[i] = 1'h0;
			endcase
		end
		return e;
	endfunction
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge clock);
		mismatches++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge clock);
		nrst <= 1'h1;
		bus_rd(pin_config_pkg::IDX_P7_UPPER, q);
		chk("upper reset", q, 32'h0);
		bus_rd(pin_config_pkg::IDX_P7_LOWER, q);
		chk("lower reset", q, 32'h0);
		bus_rd(pin_config_pkg::IDX_P6_DRIVE, q);
		chk("drive reset", q, 32'h0);
		$display("reset values done");
		foreach (rows[k]) begin
			bus_wr(pin_config_pkg::IDX_P7_UPPER, rows[k].p7u, 4'h1);
			bus_wr(pin_config_pkg::IDX_P7_LOWER, rows[k].p7l, 4'h1);
			bus_wr(pin_config_pkg::IDX_P7_DATA, rows[k].p7d, 4'h1);
			bus_wr(pin_config_pkg::IDX_P6_DRIVE, rows[k].dt, 4'h1);
			d6 <= rows[k].d6;
			e6 <= rows[k].e6;
			a6 <= rows[k].a6;
			u6 <= rows[k].u6;
			repeat (2) @(posedge clock);
			@(negedge clock);
			chk("p7 oe", pad7_oe, rows[k].x_oe7);
			chk("p7 out", pad7_out, exp7(rows[k], seg_q));
			chk("p6 oe", pad6_oe, rows[k].x_oe6);
			chk("p6 pullup", pu6, rows[k].x_pu6);
			chk("p6 out", pad6_out, rows[k].d6);
			bus_rd(pin_config_pkg::IDX_P7_LOWER, q);
			chk("lower back", q, {24'h0, rows[k].p7l});
			bus_rd(pin_config_pkg::IDX_P6_DRIVE, q);
			chk("drive back", q, {24'h0, rows[k].dt});
			$display("row %0d done", k);
		end
		bus_wr(pin_config_pkg::IDX_P7_UPPER, 8'hAA, 4'h0);
		bus_rd(pin_config_pkg::IDX_P7_UPPER, q);
		chk("masked write", q, 32'h0);
		bus_wr(8'h40, 8'hAA, 4'h1);
		bus_rd(8'h40, q);
		chk("unmapped", q, 32'h0);
		$display("refused writes done");
		bus_wr(pin_config_pkg::IDX_P7_UPPER, 8'hFF, 4'h1);
		bus_wr(pin_config_pkg::IDX_P7_LOWER, 8'hFF, 4'h1);
		bus_wr(pin_config_pkg::IDX_P7_DATA, 8'h3C, 4'h1);
		repeat (2) @(posedge clock);
		bus_rd(pin_config_pkg::IDX_P7_DATA, q);
		chk("data back", q, 32'h3C);
		bus_rd(pin_config_pkg::IDX_P7_PINS, q);
		chk("pin levels", q, 32'h3C);
		$display("pin readback done");
		bus_wr(pin_config_pkg::IDX_P7_UPPER, 8'hFF, 4'h1);
		repeat (2) @(posedge clock);
		nrst <= 1'h0;
		repeat (2) @(posedge clock);
		chk("oe in reset", pad7_oe, 32'h0);
		nrst <= 1'h1;
		bus_rd(pin_config_pkg::IDX_P7_UPPER, q);
		chk("upper after reset", q, 32'h0);
		$display("second reset done");
		close_out();
	end
endmodule // tb
`default_nettype wire
